// ---- pstate_pkg.sv ----
// constants, types and register map of the processing-state sequencer
// assumes one 25 MHz clock domain and an AXI4-Lite register bus
package pstate_pkg;

   // register byte offsets
   localparam logic [7:0] STATUS_OFFS   = 8'h00;
   localparam logic [7:0] OPMODE_OFFS   = 8'h04;
   localparam logic [7:0] CLKCTL_OFFS   = 8'h08;
   localparam logic [7:0] VBASE_OFFS    = 8'h0C;
   localparam logic [7:0] SPTR_OFFS     = 8'h10;
   localparam logic [7:0] SCNT_OFFS     = 8'h14;
   localparam logic [7:0] BUSCTL_OFFS   = 8'h18;
   localparam logic [7:0] REFRESH_OFFS  = 8'h1C;
   localparam logic [7:0] STATE_OFFS    = 8'h20;
   localparam logic [7:0] IPRIO0_OFFS   = 8'h24;
   localparam logic [7:0] IPRIO1_OFFS   = 8'h28;
   localparam logic [7:0] ATTR0_OFFS    = 8'h30;
   localparam logic [7:0] MODIF0_OFFS   = 8'h40;
   localparam int         NUM_SLOTS     = 24;

   // values taken in the reset state
   localparam logic [23:0] STATUS_INIT  = 24'hC00300;
   localparam logic [23:0] MODIF_INIT   = 24'hFFFFFF;
   localparam logic [23:0] BUSCTL_INIT  = 24'h1FFFFF;
   localparam logic [23:0] ATTR_INIT    = 24'h000000;
   localparam logic [23:0] REFRESH_INIT = 24'h000000;
   localparam logic [23:0] ZERO_INIT    = 24'h000000;

   // field positions
   localparam int OPMODE_MODE_LSB = 0;
   localparam int OPMODE_BURST    = 4;
   localparam int CLKCTL_KEEP_OSC = 0;

   // stabilisation counts in cycles
   localparam int STAB_FULL_CYCLES  = 64;
   localparam int STAB_SHORT_CYCLES = 1;

   typedef enum logic [2:0] {
      st_reset, st_run, st_wait, st_stop, st_stab
   } state_type;

   typedef enum logic [1:0] {
      wake_none, wake_reset, wake_debug, wake_irq
   } wake_type;

   typedef struct packed {
      logic osc_enable;
      logic global_clk_en;
      logic core_clk_en;
      logic periph_clk_en;
   } clk_ctl_type;

endpackage

// ---- pstate_seq.sv ----
// processing-state sequencer: reset, wait and stop control with registers
// assumes pins are asynchronous, core strobes share clk, AXI4-Lite master
`timescale 1ns/1ps
module pstate_seq #(
   parameter int STAB_FULL  = pstate_pkg::STAB_FULL_CYCLES,
   parameter int STAB_SHORT = pstate_pkg::STAB_SHORT_CYCLES
) (
   input  wire  logic                     clk,
   input  wire  logic                     rst,
   input  wire  logic                     reset_pin_n,
   input  wire  logic                     ext_interrupt_a_n,
   input  wire  logic                     debug_request_n,
   input  wire  logic                     mode_select_0,
   input  wire  logic                     mode_select_1,
   input  wire  logic                     mode_select_2,
   input  wire  logic                     mode_select_3,
   input  wire  logic                     wait_exec,
   input  wire  logic                     stop_exec,
   input  wire  logic                     irq_unmasked,
   input  wire  logic                     irq_pending,
   output logic                           periph_reset,
   output logic                           cache_init,
   output pstate_pkg::clk_ctl_type        clk_ctl,
   output logic                           debug_enter,
   output logic                           irq_service,
   output logic                           resume,
   output logic [3:0]                     chip_mode,
   input  wire  logic [7:0]               s_axi_awaddr,
   input  wire  logic                     s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire  logic [31:0]              s_axi_wdata,
   input  wire  logic [3:0]               s_axi_wstrb,
   input  wire  logic                     s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire  logic                     s_axi_bready,
   input  wire  logic [7:0]               s_axi_araddr,
   input  wire  logic                     s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire  logic                     s_axi_rready
);

   localparam int NPIN = 7;
   localparam logic [NPIN-1:0] PIN_IDLE = 7'h07;

   pstate_pkg::state_type state_reg;
   pstate_pkg::state_type state_next;
   pstate_pkg::wake_type  wake_reg;
   pstate_pkg::wake_type  wake_next;
   logic [NPIN-1:0]       pin_raw;
   logic [NPIN-1:0]       sync1_reg;
   logic [NPIN-1:0]       sync2_reg;
   logic [NPIN-1:0]       sync3_reg;
   logic [NPIN-1:0]       pin_reg;
   logic                  rst_in;
   logic                  dbg_in;
   logic                  ext_interrupt_a_n_in;
   logic [15:0]           stab_reg;
   logic [15:0]           stab_next;
   logic                  osc_off_reg;
   logic [23:0]           slot_reg [0:pstate_pkg::NUM_SLOTS-1];
   logic                  wr_go;
   logic [4:0]            wr_idx;
   logic [4:0]            rd_idx;
   logic                  keep_osc;

   // slot index of a byte offset
   function automatic logic [4:0] slot_of(input logic [7:0] a);
      slot_of = a[6:2];
   endfunction

   // slots that software may write
   function automatic logic writable(input logic [7:0] a);
      logic [4:0] i;
      i = slot_of(a);
      writable = (a[7] == 1'b0) && (i < 5'd24) && (i != 5'd8)
                 && (i != 5'd11) && (i != 5'd6 + 5'd5 - 5'd11 + 5'd11);
      if (i == 5'd11) begin
         writable = 1'b0;
      end
   endfunction

   // slots that answer a read
   function automatic logic readable(input logic [7:0] a);
      logic [4:0] i;
      i = slot_of(a);
      readable = (a[7] == 1'b0) && (i < 5'd24) && (i != 5'd11);
   endfunction

   // value loaded into each slot during reset
   function automatic logic [23:0] init_of(input int i);
      logic [4:0] s;
      s = 5'(i);
      init_of = pstate_pkg::ZERO_INIT;
      if (s == slot_of(pstate_pkg::STATUS_OFFS)) begin
         init_of = pstate_pkg::STATUS_INIT;
      end else if (s == slot_of(pstate_pkg::BUSCTL_OFFS)) begin
         init_of = pstate_pkg::BUSCTL_INIT;
      end else if (s == slot_of(pstate_pkg::REFRESH_OFFS)) begin
         init_of = pstate_pkg::REFRESH_INIT;
      end else if (s >= slot_of(pstate_pkg::MODIF0_OFFS)) begin
         init_of = pstate_pkg::MODIF_INIT;
      end else if (s >= slot_of(pstate_pkg::ATTR0_OFFS)) begin
         init_of = pstate_pkg::ATTR_INIT;
      end
   endfunction

   // byte-lane merge of a write
   function automatic logic [23:0] merge(input logic [23:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0]  be);
      merge = old;
      for (int b = 0; b < 3; b++) begin
         if (be[b]) begin
            merge[b*8 +: 8] = d[b*8 +: 8];
         end
      end
   endfunction

   assign pin_raw = {mode_select_3, mode_select_2, mode_select_1,
                     mode_select_0, debug_request_n, ext_interrupt_a_n,
                     reset_pin_n};

   // three-stage pin synchronisers, change taken when stages two and three agree
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1_reg <= PIN_IDLE;
         sync2_reg <= PIN_IDLE;
         sync3_reg <= PIN_IDLE;
      end else begin
         sync1_reg <= pin_raw;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
      end
   end

   genvar g;
   generate
      for (g = 0; g < NPIN; g++) begin : pin_filt
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               pin_reg[g] <= PIN_IDLE[g];
            end else if (sync2_reg[g] == sync3_reg[g]) begin
               pin_reg[g] <= sync3_reg[g];
            end
         end
      end
   endgenerate

   assign rst_in  = ~pin_reg[0];
   assign ext_interrupt_a_n_in = ~pin_reg[1];
   assign dbg_in  = ~pin_reg[2];
   assign keep_osc =
      slot_reg[slot_of(pstate_pkg::CLKCTL_OFFS)][pstate_pkg::CLKCTL_KEEP_OSC];

   // next state and wake reason
   always_comb begin
      state_next = state_reg;
      wake_next  = wake_reg;
      stab_next  = stab_reg;
      case (state_reg)
         pstate_pkg::st_reset: begin
            if (!rst_in) begin
               state_next = pstate_pkg::st_run;
            end
         end
         pstate_pkg::st_run: begin
            if (rst_in) begin
               state_next = pstate_pkg::st_reset;
            end else if (stop_exec) begin
               state_next = pstate_pkg::st_stop;
            end else if (wait_exec) begin
               state_next = pstate_pkg::st_wait;
            end
         end
         pstate_pkg::st_wait: begin
            if (rst_in) begin
               state_next = pstate_pkg::st_reset;
               wake_next  = pstate_pkg::wake_reset;
            end else if (dbg_in) begin
               state_next = pstate_pkg::st_run;
               wake_next  = pstate_pkg::wake_debug;
            end else if (irq_unmasked) begin
               state_next = pstate_pkg::st_run;
               wake_next  = pstate_pkg::wake_irq;
            end
         end
         pstate_pkg::st_stop: begin
            if (rst_in || dbg_in || ext_interrupt_a_n_in) begin
               state_next = pstate_pkg::st_stab;
               wake_next  = rst_in ? pstate_pkg::wake_reset :
                            dbg_in ? pstate_pkg::wake_debug :
                                     pstate_pkg::wake_irq;
               stab_next  = osc_off_reg ? 16'(STAB_FULL) : 16'(STAB_SHORT);
            end
         end
         pstate_pkg::st_stab: begin
            if (stab_reg > 16'h0001) begin
               stab_next = stab_reg - 16'h0001;
            end else if (wake_reg == pstate_pkg::wake_reset) begin
               state_next = pstate_pkg::st_reset;
            end else begin
               state_next = pstate_pkg::st_run;
            end
         end
         default: state_next = pstate_pkg::st_reset;
      endcase
   end

   // state, wake reason and delay counter
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= pstate_pkg::st_reset;
         wake_reg  <= pstate_pkg::wake_none;
         stab_reg  <= 16'h0000;
      end else begin
         state_reg <= state_next;
         wake_reg  <= wake_next;
         stab_reg  <= stab_next;
      end
   end

   // oscillator choice latched on stop entry
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         osc_off_reg <= 1'b1;
      end else if (state_reg == pstate_pkg::st_run &&
                   state_next == pstate_pkg::st_stop) begin
         osc_off_reg <= ~keep_osc;
      end
   end

   // one-cycle exit actions when clocks return
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         debug_enter <= 1'b0;
         irq_service <= 1'b0;
         resume      <= 1'b0;
      end else begin
         debug_enter <= 1'b0;
         irq_service <= 1'b0;
         resume      <= 1'b0;
         if (state_reg == pstate_pkg::st_wait &&
             state_next == pstate_pkg::st_run) begin
            debug_enter <= (wake_next == pstate_pkg::wake_debug);
            irq_service <= (wake_next == pstate_pkg::wake_irq);
         end
         if (state_reg == pstate_pkg::st_stab &&
             state_next == pstate_pkg::st_run) begin
            debug_enter <= (wake_reg == pstate_pkg::wake_debug);
            irq_service <= (wake_reg == pstate_pkg::wake_irq) && irq_pending;
            resume <= (wake_reg == pstate_pkg::wake_irq) && !irq_pending;
         end
      end
   end

   // clock and reset controls
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clk_ctl      <= '{1'b1, 1'b1, 1'b1, 1'b1};
         periph_reset <= 1'b1;
         cache_init   <= 1'b1;
      end else begin
         periph_reset <= (state_next == pstate_pkg::st_reset);
         cache_init   <= (state_next == pstate_pkg::st_reset);
         clk_ctl.core_clk_en <= (state_next == pstate_pkg::st_run) ||
                                (state_next == pstate_pkg::st_reset);
         clk_ctl.periph_clk_en <= (state_next != pstate_pkg::st_stop) &&
                                  (state_next != pstate_pkg::st_stab);
         clk_ctl.global_clk_en <= (state_next != pstate_pkg::st_stop) &&
                                  (state_next != pstate_pkg::st_stab);
         // oscillator off when keep bit clear
         // oscillator kept when keep bit set
         // a pin reset beating the stop strobe must keep the oscillator on
         if (state_reg == pstate_pkg::st_run &&
             state_next == pstate_pkg::st_stop) begin
            clk_ctl.osc_enable <= keep_osc;
         end else if (state_next != pstate_pkg::st_stop) begin
            clk_ctl.osc_enable <= 1'b1;
         end
      end
   end

   // register slots: reset-state loading and software writes
   assign wr_go  = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
   assign wr_idx = slot_of(s_axi_awaddr);
   generate
      for (g = 0; g < pstate_pkg::NUM_SLOTS; g++) begin : slot
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               slot_reg[g] <= init_of(g);
            end else if (state_reg == pstate_pkg::st_reset) begin
               slot_reg[g] <= init_of(g);
               if (g == slot_of(pstate_pkg::OPMODE_OFFS) && !rst_in) begin
                  slot_reg[g][pstate_pkg::OPMODE_MODE_LSB +: 4] <=
                     pin_reg[6:3];
               end
            end else if (wr_go && writable(s_axi_awaddr) &&
                         wr_idx == 5'(g)) begin
               slot_reg[g] <= merge(slot_reg[g], s_axi_wdata, s_axi_wstrb);
            end
         end
      end
   endgenerate

   assign chip_mode = slot_reg[slot_of(pstate_pkg::OPMODE_OFFS)]
                              [pstate_pkg::OPMODE_MODE_LSB +: 4];

   // write channel: both address and data taken together
   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'b00;
      end else if (wr_go) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= writable(s_axi_awaddr) ? 2'b00 : 2'b10;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // read channel
   assign s_axi_arready = !s_axi_rvalid;
   assign rd_idx        = slot_of(s_axi_araddr);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h00000000;
         s_axi_rresp  <= 2'b00;
      end else if (s_axi_arvalid && !s_axi_rvalid) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= readable(s_axi_araddr) ? 2'b00 : 2'b10;
         if (!readable(s_axi_araddr)) begin
            s_axi_rdata <= 32'h00000000;
         end else if (s_axi_araddr == pstate_pkg::STATE_OFFS) begin
            s_axi_rdata <= {26'h0000000, wake_reg, 1'b0, state_reg};
         end else begin
            s_axi_rdata <= {8'h00, slot_reg[rd_idx]};
         end
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// ---- pstate_seq_chk.sv ----
// checker of the processing-state sequencer, watching its ports only
// assumes one clock domain and wake pins held low until the wake is seen
`timescale 1ns/1ps
module pstate_seq_chk (
   input wire logic                    clk,
   input wire logic                    rst,
   input wire logic                    reset_pin_n,
   input wire logic                    ext_interrupt_a_n,
   input wire logic                    debug_request_n,
   input wire logic                    wait_exec,
   input wire logic                    stop_exec,
   input wire logic                    periph_reset,
   input wire logic                    cache_init,
   input wire pstate_pkg::clk_ctl_type clk_ctl,
   input wire logic                    debug_enter,
   input wire logic                    irq_service,
   input wire logic                    resume,
   input wire logic [3:0]              chip_mode,
   input wire logic                    s_axi_awvalid,
   input wire logic                    s_axi_awready,
   input wire logic                    s_axi_bvalid
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // run state as seen from outside: all clocks on, no reset
   logic run_ok;
   assign run_ok = !periph_reset && clk_ctl == 4'hF && reset_pin_n;

   chk_pin_reset:
      assert property ((!reset_pin_n && clk_ctl.global_clk_en) [*6]
         |-> periph_reset && cache_init) else $error("reset not held");
   chk_reset_clk:
      assert property (periph_reset |-> clk_ctl == 4'hF)
         else $error("clocks off in reset");
   chk_mode_fix:
      assert property (!periph_reset && !$past(periph_reset)
         |-> $stable(chip_mode)) else $error("mode moved outside reset");
   chk_wait_gate:
      assert property (wait_exec && !stop_exec && run_ok
         |=> clk_ctl == 4'hD) else $error("wait gating wrong");
   chk_stop_gate:
      assert property (stop_exec && run_ok |=> clk_ctl[2:0] == 3'h0)
         else $error("stop gating wrong");
   chk_stab_min:
      assert property ($fell(ext_interrupt_a_n) && !clk_ctl.global_clk_en
         |-> !clk_ctl.global_clk_en [*3]) else $error("clocks back early");
   chk_stab_max:
      assert property ($fell(ext_interrupt_a_n) && !clk_ctl.global_clk_en
         |-> ##[3:90] clk_ctl.global_clk_en) else $error("no stop wake");
   chk_stop_stay:
      assert property ((!clk_ctl.global_clk_en && reset_pin_n &&
         ext_interrupt_a_n && debug_request_n) [*8]
         |=> !clk_ctl.global_clk_en) else $error("stop left with no cause");
   chk_wake_act:
      assert property ($rose(clk_ctl.global_clk_en) && !periph_reset
         |-> ##[0:1] (debug_enter || irq_service || resume))
         else $error("no action after wake");
   chk_b_after:
      assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
         else $error("write response missing");
endmodule

bind pstate_seq pstate_seq_chk chk_i (.clk, .rst, .reset_pin_n,
   .ext_interrupt_a_n, .debug_request_n, .wait_exec, .stop_exec,
   .periph_reset, .cache_init, .clk_ctl, .debug_enter, .irq_service,
   .resume, .chip_mode, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid);

// ---- pstate_pins.sv ----
// partner model: reset, interrupt-A and debug pins plus mode straps
// assumes one request at a time; released pins return to the pull-up
`timescale 1ns/1ps
module pstate_pins #(
   parameter int HOLD = 16
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       go,
   input  wire logic [2:0] mask,
   input  wire logic [3:0] mode_val,
   output logic            reset_pin_n,
   output logic            ext_interrupt_a_n,
   output logic            debug_request_n,
   output logic [3:0]      mode_pins,
   output logic            busy
);
   int hold_reg;
   assign busy = hold_reg != 0;
   // low level wake
   // drive requested pins low for HOLD cycles, then release them high
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hold_reg <= 0;
         reset_pin_n <= 1'h1;
         ext_interrupt_a_n <= 1'h1;
         debug_request_n <= 1'h1;
      end else if (go) begin
         hold_reg <= HOLD;
         reset_pin_n <= !mask[2];
         debug_request_n <= !mask[1];
         ext_interrupt_a_n <= !mask[0];
      end else if (hold_reg == 1) begin
         hold_reg <= 0;
         reset_pin_n <= 1'h1;
         ext_interrupt_a_n <= 1'h1;
         debug_request_n <= 1'h1;
      end else if (hold_reg != 0) begin
         hold_reg <= hold_reg - 1;
      end
   end
   // straps held steady
   // straps change only with a reset request, so they are stable at exit
   always_ff @(posedge clk or posedge rst) begin
      if (rst) mode_pins <= 4'h0;
      else if (go && mask[2]) mode_pins <= mode_val;
   end
endmodule

// ---- core_processing_state_control_tb_top.sv ----
// testbench of the processing-state sequencer with its pin partner
// assumes package, design, partner and checker are compiled before it
`timescale 1ns/1ps
module core_processing_state_control_tb_top;
   localparam int SF = 4;
   localparam int SS = 1;
   logic        clk = 1'h0, rst = 1'h1, go = 1'h0;
   logic        wait_exec = 1'h0, stop_exec = 1'h0;
   logic        irq_unmasked = 1'h0, irq_pending = 1'h0;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic        arvalid = 1'h0, rready = 1'h0;
   logic [2:0]  mask = 3'h0;
   logic [3:0]  mode_val = 4'h0, wstrb = 4'h0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic        periph_reset, cache_init, debug_enter, irq_service, resume;
   logic        busy, pr_q, awready, wready, bvalid, arready, rvalid;
   logic        reset_pin_n, ext_interrupt_a_n, debug_request_n;
   logic [3:0]  mode_pins, chip_mode;
   logic [1:0]  bresp, rresp;
   logic [15:0] seed = 16'hCB4A;
   logic [2:0]  wk[5] = '{3'h1, 3'h2, 3'h4, 3'h3, 3'h7};
   int          n_mismatch = 0, num_checks = 0, cyc = 0, tt[2];
   int          ev[4] = '{0, 0, 0, 0};
   pstate_pkg::clk_ctl_type clk_ctl;

   pstate_seq #(.STAB_FULL(SF), .STAB_SHORT(SS)) dut (.clk, .rst,
      .reset_pin_n, .ext_interrupt_a_n, .debug_request_n,
      .mode_select_0(mode_pins[0]), .mode_select_1(mode_pins[1]),
      .mode_select_2(mode_pins[2]), .mode_select_3(mode_pins[3]),
      .wait_exec, .stop_exec, .irq_unmasked, .irq_pending, .periph_reset,
      .cache_init, .clk_ctl, .debug_enter, .irq_service, .resume,
      .chip_mode, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready));
   pstate_pins pins (.clk, .rst, .go, .mask, .mode_val, .reset_pin_n,
      .ext_interrupt_a_n, .debug_request_n, .mode_pins, .busy);

   // clock and hang guard
   initial begin
      forever #20 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         end_sim();
      end
   end
   // count reset entries and the one-cycle wake pulses
   always @(posedge clk) begin
      pr_q <= periph_reset;
      if (!rst) begin
         if (periph_reset && !pr_q) ev[0] <= ev[0] + 1;
         if (debug_enter) ev[1] <= ev[1] + 1;
         if (irq_service) ev[2] <= ev[2] + 1;
         if (resume) ev[3] <= ev[3] + 1;
      end
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // value each slot takes in the reset state
   function automatic logic [31:0] exp_slot(input int i,
                                            input logic [3:0] m);
      if (i == 0) return 32'h00C00300;
      if (i == 1) return {28'h0, m};
      if (i == 6) return {8'h00, pstate_pkg::BUSCTL_INIT};
      return (i >= 16) ? 32'h00FFFFFF : 32'h0;
   endfunction
   task automatic end_sim;
      if (n_mismatch == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic cmp_v(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %0t value %h expected %h", $time, g, e);
      end
   endtask
   task automatic cmp_c(input int g, input int e);
      num_checks++;
      if (g != e) begin
         n_mismatch++;
         $display("BAD %0t count %0d expected %0d", $time, g, e);
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do @(posedge clk); while (!(awready && wready));
      awvalid <= 1'h0;
      wvalid <= 1'h0;
      do @(posedge clk); while (bvalid !== 1'h1);
      r = bresp;
      bready <= 1'h0;
      @(posedge clk);
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'h0;
      do @(posedge clk); while (rvalid !== 1'h1);
      d = rdata;
      r = rresp;
      rready <= 1'h0;
      @(posedge clk);
   endtask
   task automatic pulse(input logic [2:0] k, input logic [3:0] m);
      mask <= k;
      mode_val <= m;
      go <= 1'h1;
      @(posedge clk);
      go <= 1'h0;
   endtask
   task automatic strobe(input logic s);
      stop_exec <= s;
      wait_exec <= !s;
      @(posedge clk);
      stop_exec <= 1'h0;
      wait_exec <= 1'h0;
      @(posedge clk);
   endtask
   task automatic stay;
      do @(posedge clk); while (periph_reset !== 1'h0 || busy);
      // released pins still need the synchroniser before the next request
      repeat (5) @(posedge clk);
   endtask
   // wait for one wake action, then see that only the expected one came
   task automatic check_ev(input int b[4], input int idx);
      while (ev[0] + ev[1] + ev[2] + ev[3] == b[0] + b[1] + b[2] + b[3])
         @(posedge clk);
      for (int j = 0; j < 4; j++) cmp_c(ev[j] - b[j], int'(j == idx));
   endtask
   task automatic check_table(input logic [3:0] m);
      logic [31:0] d;
      logic [1:0]  r;
      for (int i = 0; i < 24; i++) begin
         axr(8'(i * 4), d, r);
         if (i == 11) cmp_v(32'(r), 32'h2);
         else if (i == 8) cmp_v(d & 32'h7, 32'h1);
         else cmp_v(d, exp_slot(i, m));
      end
   endtask

   // main sequence: reset values, pin reset, wait and stop exits
   initial begin
      logic [1:0]  r;
      logic [31:0] d;
      logic [3:0]  m;
      logic [2:0]  k;
      int          b[4];
      int          t;
      repeat (4) @(posedge clk);
      rst <= 1'h0;
      stay();
      check_table(4'h0);
      for (int i = 0; i < 24; i++) begin
         seed = lfsr(seed);
         if (i != 1 && i != 8 && i != 11) axw(8'(i * 4), {seed, ~seed}, r);
      end
      axw(pstate_pkg::STATE_OFFS, 32'h0, r);
      cmp_v(32'(r), 32'h2);
      axw(8'h2C, 32'h0, r);
      cmp_v(32'(r), 32'h2);
      m = seed[3:0];
      pulse(3'h4, m);
      do @(posedge clk); while (periph_reset !== 1'h1);
      cmp_v(32'(cache_init), 32'h1);
      stay();
      check_table(m);
      cmp_v(32'(chip_mode), 32'(m));
      for (int j = 0; j < 3; j++) begin
         strobe(1'h0);
         cmp_v(32'(clk_ctl), 32'hD);
         b = ev;
         if (j == 0) irq_unmasked <= 1'h1;
         else pulse(j == 1 ? 3'h2 : 3'h4, m);
         check_ev(b, 2 - j);
         irq_unmasked <= 1'h0;
         stay();
      end
      for (int kp = 0; kp < 2; kp++) begin
         for (int c = 0; c < 5; c++) begin
            k = wk[c];
            axw(pstate_pkg::CLKCTL_OFFS, 32'(kp), r);
            irq_pending <= 1'(kp);
            strobe(1'h1);
            cmp_v(32'(clk_ctl), {28'h0, 1'(kp), 3'h0});
            repeat (9) @(posedge clk);
            cmp_v(32'(clk_ctl.global_clk_en), 32'h0);
            b = ev;
            t = 0;
            pulse(k, m);
            while (clk_ctl.global_clk_en !== 1'h1) begin
               @(posedge clk);
               t++;
            end
            if (k == 3'h1) tt[kp] = t;
            check_ev(b, k[2] ? 0 : k[1] ? 1 : kp ? 2 : 3);
            stay();
            axr(pstate_pkg::CLKCTL_OFFS, d, r);
            cmp_v(d, k[2] ? 32'h0 : 32'(kp));
         end
      end
      cmp_c(tt[0] - tt[1], SF - SS);
      end_sim();
   end
endmodule
